// [hdl/vccr_axil_port.sv]
// axi4-lite slave front end: one write and one read at a time
`timescale 1ns/100ps
module vccr_axil_port (
	input  wire logic                     ref_clk_i,
	input  wire logic                     arst_n_i,
	input  wire logic [vccr_pkg::ADDR_W-1:0] awaddr_i,
	input  wire logic                     awvalid_i,
	output      logic                     awready_o,
	input  wire logic [vccr_pkg::DATA_W-1:0] wdata_i,
	input  wire logic [3:0]               wstrb_i,
	input  wire logic                     wvalid_i,
	output      logic                     wready_o,
	output      logic [1:0]               bresp_o,
	output      logic                     bvalid_o,
	input  wire logic                     bready_i,
	input  wire logic [vccr_pkg::ADDR_W-1:0] araddr_i,
	input  wire logic                     arvalid_i,
	output      logic                     arready_o,
	output      logic [vccr_pkg::DATA_W-1:0] rdata_o,
	output      logic [1:0]               rresp_o,
	output      logic                     rvalid_o,
	input  wire logic                     rready_i,
	output      logic                     wr_en_o,
	output      logic [vccr_pkg::ADDR_W-1:0] wr_addr_o,
	output      logic [vccr_pkg::DATA_W-1:0] wr_data_o,
	output      logic [3:0]               wr_strb_o,
	input  wire logic                     wr_hit_i,
	output      logic                     rd_en_o,
	output      logic [vccr_pkg::ADDR_W-1:0] rd_addr_o,
	input  wire logic [vccr_pkg::DATA_W-1:0] rd_data_i,
	input  wire logic                     rd_hit_i
);
	import vccr_pkg::*;

	typedef struct packed {
		logic              aw_got;
		logic [ADDR_W-1:0] aw_addr;
		logic              w_got;
		logic [DATA_W-1:0] w_data;
		logic [3:0]        w_strb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
	} vccr_axil_st_t;

	vccr_axil_st_t st_ff;
	vccr_axil_st_t nxt_st;

	assign awready_o = !st_ff.aw_got && !st_ff.bvalid;
	assign wready_o  = !st_ff.w_got && !st_ff.bvalid;
	assign arready_o = !st_ff.rvalid;
	assign bvalid_o  = st_ff.bvalid;
	assign bresp_o   = st_ff.bresp;
	assign rvalid_o  = st_ff.rvalid;
	assign rdata_o   = st_ff.rdata;
	assign rresp_o   = st_ff.rresp;
	assign wr_en_o   = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
	assign wr_addr_o = st_ff.aw_addr;
	assign wr_data_o = st_ff.w_data;
	assign wr_strb_o = st_ff.w_strb;
	assign rd_en_o   = arvalid_i && arready_o;
	assign rd_addr_o = araddr_i;

	always_comb begin
		nxt_st = st_ff;
		if (awvalid_i && awready_o) begin
			nxt_st.aw_got  = 1'b1;
			nxt_st.aw_addr = awaddr_i;
		end
		if (wvalid_i && wready_o) begin
			nxt_st.w_got  = 1'b1;
			nxt_st.w_data = wdata_i;
			nxt_st.w_strb = wstrb_i;
		end
		if (wr_en_o) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got  = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp  = wr_hit_i ? RESP_OKAY : RESP_SLVERR;
		end else if (st_ff.bvalid && bready_i) begin
			nxt_st.bvalid = 1'b0;
		end
		if (rd_en_o) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata  = rd_data_i;
			nxt_st.rresp  = rd_hit_i ? RESP_OKAY : RESP_SLVERR;
		end else if (st_ff.rvalid && rready_i) begin
			nxt_st.rvalid = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);

	a_write_resp_follows: assert property (
		wr_en_o |=> bvalid_o && !awready_o && !wready_o)
		else $error("write response did not follow write");
	a_bvalid_held: assert property (
		bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
		else $error("write response dropped before bready");
	a_read_data_next: assert property (
		rd_en_o |=> rvalid_o && rdata_o == $past(rd_data_i))
		else $error("read data not returned next cycle");
endmodule : vccr_axil_port

// [hdl/vccr_mode_check.sv]
// judges the video setting combination and the effective pixel depth
`timescale 1ns/100ps
module vccr_mode_check #(
	parameter logic [7:0] MODE_OK_F0 = 8'h3f,
	parameter logic [7:0] MODE_OK_F1 = 8'h3f,
	parameter logic [7:0] MODE_OK_F2 = 8'h3f,
	parameter logic [7:0] WIDE_F0    = 8'h40,
	parameter logic [7:0] WIDE_F1    = 8'h20,
	parameter logic [7:0] WIDE_F2    = 8'h20,
	parameter logic [7:0] RATE_OK    = 8'h1f,
	parameter logic [1:0] SPEED_MIN  = 2'h2
) (
	input  wire logic [2:0]                 fmt_i,
	input  wire logic [2:0]                 mode_i,
	input  wire logic [2:0]                 rate_i,
	input  wire logic [1:0]                 iso_speed_i,
	input  wire logic                       scal_wide_i,
	output      logic                       fault_o,
	output      logic [vccr_pkg::DEPTH_W-1:0] depth_o
);
	import vccr_pkg::*;

	function automatic logic mode_bit(input logic [7:0] m0,
		input logic [7:0] m1, input logic [7:0] m2,
		input logic [2:0] f, input logic [2:0] m);
		logic [7:0] sel;
		sel = (f == 3'h0) ? m0 : ((f == 3'h1) ? m1 : m2);
		return sel[m];
	endfunction : mode_bit

	logic std_fmt;
	logic wide;

	always_comb begin
		std_fmt = fmt_i <= FMT_STD_LAST;
		fault_o = 1'b0;
		wide    = scal_wide_i;
		if (std_fmt) begin
			// acceptable only when mode, rate and speed all agree
			fault_o = !mode_bit(MODE_OK_F0, MODE_OK_F1, MODE_OK_F2,
				fmt_i, mode_i) || !RATE_OK[rate_i] ||
				iso_speed_i < SPEED_MIN;
			wide = mode_bit(WIDE_F0, WIDE_F1, WIDE_F2, fmt_i, mode_i);
		end else if (fmt_i != FMT_SCAL) begin
			fault_o = 1'b1;
		end
		depth_o = wide ? DEPTH_MONO16 : DEPTH_MONO8;
	end

	a_scal_no_fault: assert final (
		fmt_i != FMT_SCAL || !fault_o)
		else $error("fault flagged under scalable format");
	a_depth_codes: assert final (
		depth_o == DEPTH_MONO8 || depth_o == DEPTH_MONO16)
		else $error("depth code out of range");
endmodule : vccr_mode_check

// [hdl/vccr_pkg.sv]
// constants and register map of the video capture control registers
package vccr_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	typedef logic [ADDR_W-1:0] vccr_addr_t;

	// register byte offsets
	localparam vccr_addr_t OFS_SHOT    = 12'h61c;
	localparam vccr_addr_t OFS_FAULT   = 12'h628;
	localparam vccr_addr_t OFS_TRIG    = 12'h62c;
	localparam vccr_addr_t OFS_DEPTH   = 12'h630;
	localparam vccr_addr_t OFS_IRQ_STS = 12'h640;
	localparam vccr_addr_t OFS_IRQ_MSK = 12'h644;

	// field positions
	localparam int BIT_SHOT  = 0;
	localparam int BIT_FAULT = 0;
	localparam int BIT_TRIG  = 0;
	localparam int DEPTH_W   = 8;

	// reset values
	localparam logic SHOT_RST  = 1'b0;
	localparam logic TRIG_RST  = 1'b0;
	localparam logic FAULT_RST = 1'b0;

	// video setting codes
	localparam logic [2:0] FMT_STD_LAST = 3'h2;
	localparam logic [2:0] FMT_SCAL     = 3'h7;
	localparam logic [3:0] TRIG_STYLE_SELFCLR = 4'h0;

	// effective depth codes
	localparam logic [DEPTH_W-1:0] DEPTH_MONO8  = 8'h08;
	localparam logic [DEPTH_W-1:0] DEPTH_MONO16 = 8'h0a;

	// interrupt status / mask layout
	localparam int IRQ_N     = 3;
	localparam int IRQ_FRAME = 0;
	localparam int IRQ_FAULT = 1;
	localparam int IRQ_TRIG  = 2;
	localparam logic [IRQ_N-1:0] IRQ_MSK_RST = 3'h0;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : vccr_pkg

// [hdl/vccr_regs.sv]
// video capture control register bank with axi4-lite access
`timescale 1ns/100ps
module vccr_regs (
	input  wire logic                     ref_clk_i,
	input  wire logic                     arst_n_i,
	input  wire logic [vccr_pkg::ADDR_W-1:0] s_axi_awaddr_i,
	input  wire logic                     s_axi_awvalid_i,
	output      logic                     s_axi_awready_o,
	input  wire logic [vccr_pkg::DATA_W-1:0] s_axi_wdata_i,
	input  wire logic [3:0]               s_axi_wstrb_i,
	input  wire logic                     s_axi_wvalid_i,
	output      logic                     s_axi_wready_o,
	output      logic [1:0]               s_axi_bresp_o,
	output      logic                     s_axi_bvalid_o,
	input  wire logic                     s_axi_bready_i,
	input  wire logic [vccr_pkg::ADDR_W-1:0] s_axi_araddr_i,
	input  wire logic                     s_axi_arvalid_i,
	output      logic                     s_axi_arready_o,
	output      logic [vccr_pkg::DATA_W-1:0] s_axi_rdata_o,
	output      logic [1:0]               s_axi_rresp_o,
	output      logic                     s_axi_rvalid_o,
	input  wire logic                     s_axi_rready_i,
	input  wire logic [2:0]               video_fmt_i,
	input  wire logic [2:0]               video_mode_i,
	input  wire logic [2:0]               frame_rate_i,
	input  wire logic [1:0]               iso_speed_i,
	input  wire logic                     scal_wide_i,
	input  wire logic                     trig_src_sw_i,
	input  wire logic [3:0]               trig_style_i,
	input  wire logic                     frame_done_i,
	output      logic                     frame_req_o,
	output      logic                     sw_trigger_o,
	output      logic                     setting_fault_o,
	output      logic                     irq_o
);
	import vccr_pkg::*;

	typedef struct packed {
		logic             shot;
		logic             trig;
		logic             fault;
		logic             evald;
		logic [10:0]      prev;
		logic [IRQ_N-1:0] sts;
		logic [IRQ_N-1:0] msk;
	} vccr_regs_st_t;

	vccr_regs_st_t st_ff;
	vccr_regs_st_t nxt_st;

	logic              wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [3:0]        wr_strb;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_data;
	logic              chk_fault;
	logic [DEPTH_W-1:0] chk_depth;
	logic [10:0]       settings;
	logic              shot_fmt_ok;
	logic              wr_low;
	logic              wr_shot;
	logic              wr_trig;
	logic              eval;
	logic [IRQ_N-1:0]  ev;
	logic [IRQ_N-1:0]  sts_kill;

	function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
		return a == OFS_SHOT || a == OFS_FAULT || a == OFS_TRIG ||
			a == OFS_DEPTH || a == OFS_IRQ_STS || a == OFS_IRQ_MSK;
	endfunction : reg_hit

	vccr_axil_port u_port (
		.ref_clk_i (ref_clk_i),
		.arst_n_i  (arst_n_i),
		.awaddr_i  (s_axi_awaddr_i),
		.awvalid_i (s_axi_awvalid_i),
		.awready_o (s_axi_awready_o),
		.wdata_i   (s_axi_wdata_i),
		.wstrb_i   (s_axi_wstrb_i),
		.wvalid_i  (s_axi_wvalid_i),
		.wready_o  (s_axi_wready_o),
		.bresp_o   (s_axi_bresp_o),
		.bvalid_o  (s_axi_bvalid_o),
		.bready_i  (s_axi_bready_i),
		.araddr_i  (s_axi_araddr_i),
		.arvalid_i (s_axi_arvalid_i),
		.arready_o (s_axi_arready_o),
		.rdata_o   (s_axi_rdata_o),
		.rresp_o   (s_axi_rresp_o),
		.rvalid_o  (s_axi_rvalid_o),
		.rready_i  (s_axi_rready_i),
		.wr_en_o   (wr_en),
		.wr_addr_o (wr_addr),
		.wr_data_o (wr_data),
		.wr_strb_o (wr_strb),
		.wr_hit_i  (reg_hit(wr_addr)),
		.rd_en_o   (),
		.rd_addr_o (rd_addr),
		.rd_data_i (rd_data),
		.rd_hit_i  (reg_hit(rd_addr))
	);

	vccr_mode_check u_check (
		.fmt_i       (video_fmt_i),
		.mode_i      (video_mode_i),
		.rate_i      (frame_rate_i),
		.iso_speed_i (iso_speed_i),
		.scal_wide_i (scal_wide_i),
		.fault_o     (chk_fault),
		.depth_o     (chk_depth)
	);

	assign settings = {video_fmt_i, video_mode_i, frame_rate_i, iso_speed_i};
	assign shot_fmt_ok = video_fmt_i <= FMT_STD_LAST ||
		video_fmt_i == FMT_SCAL;
	// only the low byte holds live bits; other lanes are ignored
	assign wr_low  = wr_en && wr_strb[0];
	assign wr_shot = wr_low && wr_addr == OFS_SHOT;
	assign wr_trig = wr_low && wr_addr == OFS_TRIG;
	// any change of the four settings forces a fresh verdict
	assign eval = !st_ff.evald || settings != st_ff.prev;
	// status bits that a write clears and no event of that cycle keeps set
	assign sts_kill = (wr_low && wr_addr == OFS_IRQ_STS) ?
		wr_data[IRQ_N-1:0] & ~ev : '0;

	always_comb begin
		nxt_st = st_ff;
		ev     = '0;
		// burst bit and count field are never looked at
		if (wr_shot && wr_data[BIT_SHOT] && shot_fmt_ok) begin
			nxt_st.shot = 1'b1;
		end else if (frame_done_i) begin
			nxt_st.shot = 1'b0;
		end
		ev[IRQ_FRAME] = st_ff.shot && frame_done_i;

		if (wr_trig) begin
			nxt_st.trig = wr_data[BIT_TRIG];
		end else if (trig_style_i == TRIG_STYLE_SELFCLR) begin
			nxt_st.trig = 1'b0;
		end
		ev[IRQ_TRIG] = nxt_st.trig && !st_ff.trig && trig_src_sw_i;

		if (eval) begin
			nxt_st.fault = chk_fault;
			nxt_st.prev  = settings;
			nxt_st.evald = 1'b1;
		end
		ev[IRQ_FAULT] = nxt_st.fault && !st_ff.fault;

		// write-one-to-clear, a new event in the same cycle wins
		if (wr_low && wr_addr == OFS_IRQ_STS) begin
			nxt_st.sts = st_ff.sts & ~wr_data[IRQ_N-1:0];
		end
		nxt_st.sts = nxt_st.sts | ev;
		if (wr_low && wr_addr == OFS_IRQ_MSK) begin
			nxt_st.msk = wr_data[IRQ_N-1:0];
		end
	end

	always_comb begin
		rd_data = '0; // reserved bits and unmapped reads return zero
		if (rd_addr == OFS_SHOT) begin
			rd_data[BIT_SHOT] = st_ff.shot;
		end else if (rd_addr == OFS_FAULT) begin
			rd_data[BIT_FAULT] = st_ff.fault;
		end else if (rd_addr == OFS_TRIG) begin
			rd_data[BIT_TRIG] = st_ff.trig;
		end else if (rd_addr == OFS_DEPTH) begin
			rd_data[DEPTH_W-1:0] = chk_depth;
		end else if (rd_addr == OFS_IRQ_STS) begin
			rd_data[IRQ_N-1:0] = st_ff.sts;
		end else if (rd_addr == OFS_IRQ_MSK) begin
			rd_data[IRQ_N-1:0] = st_ff.msk;
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_ff.shot  <= SHOT_RST;
			st_ff.trig  <= TRIG_RST;
			st_ff.fault <= FAULT_RST;
			st_ff.evald <= 1'b0;
			st_ff.prev  <= '0;
			st_ff.sts   <= '0;
			st_ff.msk   <= IRQ_MSK_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign frame_req_o     = st_ff.shot;
	assign sw_trigger_o    = st_ff.trig && trig_src_sw_i;
	assign setting_fault_o = st_ff.fault;
	assign irq_o           = |(st_ff.sts & st_ff.msk);

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_shot_req;
		wr_shot && wr_data[BIT_SHOT] && shot_fmt_ok;
	endsequence
	sequence s_frame_end;
		!wr_shot && frame_done_i;
	endsequence

	a_shot_starts: assert property (
		s_shot_req |=> frame_req_o)
		else $error("frame request not raised by write");
	a_shot_bad_fmt: assert property (
		wr_shot && !shot_fmt_ok && !frame_req_o |=> !frame_req_o)
		else $error("frame request raised in unsupported format");
	a_shot_self_clr: assert property (
		frame_req_o ##0 s_frame_end |=> !frame_req_o && st_ff.sts[IRQ_FRAME])
		else $error("frame request not cleared at frame end");
	a_burst_ignored: assert property (
		wr_shot && !wr_data[BIT_SHOT] && !frame_req_o |=> !frame_req_o)
		else $error("burst fields changed the frame request");
	a_fault_eval: assert property (
		$changed(settings) |=> setting_fault_o == $past(chk_fault))
		else $error("fault flag not refreshed on setting change");
	a_fault_steady: assert property (
		$stable(settings) [*3] |-> $stable(setting_fault_o))
		else $error("fault flag moved with stable settings");
	a_trig_self_clr: assert property (
		st_ff.trig && trig_style_i == TRIG_STYLE_SELFCLR && !wr_trig
		|=> !st_ff.trig)
		else $error("trigger bit did not self clear");
	a_trig_gate: assert property (
		!trig_src_sw_i |-> !sw_trigger_o)
		else $error("software trigger leaked to other origin");
	a_resv_zero: assert property (
		rd_addr == OFS_FAULT || rd_addr == OFS_SHOT
		|-> rd_data[DATA_W-1:1] == '0)
		else $error("reserved bits read non-zero");

	sequence s_msk_write;
		wr_low && wr_addr == OFS_IRQ_MSK;
	endsequence
	sequence s_trig_release;
		wr_trig && !wr_data[BIT_TRIG];
	endsequence

	a_shot_holds: assert property (
		frame_req_o && !frame_done_i |=> frame_req_o)
		else $error("frame request dropped before frame end");
	a_trig_release: assert property (
		s_trig_release |=> !st_ff.trig)
		else $error("trigger bit not released by write");
	a_trig_hold: assert property (
		!wr_trig && trig_style_i != TRIG_STYLE_SELFCLR
		|=> $stable(st_ff.trig))
		else $error("trigger bit moved without a write");
	a_trig_event: assert property (
		wr_trig && wr_data[BIT_TRIG] && !st_ff.trig && trig_src_sw_i
		|=> st_ff.sts[IRQ_TRIG])
		else $error("software trigger event not flagged");

	// fault flag always carries the verdict of the previous cycle
	a_fault_track: assert property (
		1'b1 |=> setting_fault_o == $past(chk_fault))
		else $error("fault flag does not follow the verdict");
	a_fault_scal: assert property (
		video_fmt_i == FMT_SCAL |=> !setting_fault_o)
		else $error("fault flag set under scalable format");
	a_fault_event: assert property (
		$rose(setting_fault_o) |-> st_ff.sts[IRQ_FAULT])
		else $error("fault rise not flagged in status");

	// interrupt status and mask
	a_event_sticky: assert property (
		ev != '0 |=> (st_ff.sts & $past(ev)) == $past(ev))
		else $error("event lost in interrupt status");
	a_sts_w1c: assert property (
		sts_kill != '0 |=> (st_ff.sts & $past(sts_kill)) == '0)
		else $error("status bit not cleared by write of one");
	a_msk_write: assert property (
		s_msk_write |=> st_ff.msk == IRQ_N'($past(wr_data)))
		else $error("mask register did not take written value");
	a_unmapped_quiet: assert property (
		wr_en && !reg_hit(wr_addr) |=> $stable(st_ff.msk))
		else $error("unmapped write changed the mask");

	// read side
	a_resv_depth: assert property (
		rd_addr == OFS_DEPTH
		|-> rd_data[DATA_W-1:DEPTH_W] == '0)
		else $error("reserved depth bits read non-zero");
	a_rd_unmapped: assert property (
		!reg_hit(rd_addr) |-> rd_data == '0)
		else $error("unmapped read returned non-zero");
endmodule : vccr_regs

// [verification/testbench.sv]
// self-checking bench for the video capture control register bank
`timescale 1ns/100ps
module testbench;
	import vccr_pkg::*;
	logic        ref_clk_i;
	logic        arst_n_i;
	vccr_addr_t  awaddr;
	vccr_addr_t  araddr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [3:0]  wstrb;
	logic [3:0]  style;
	logic [2:0]  fmt;
	logic [2:0]  mode;
	logic [2:0]  rate;
	logic [1:0]  spd;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic        wide, src_sw, done, freq, trig, fault, irq;
	logic [33:0] wq[$];
	logic [33:0] rq[$];
	int          failures;
	int          comparisons;
	int          trig_cycles;
	int          n0;
	logic [2:0]  f, m, r;

	vccr_regs vccr_regs_inst (
		.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .video_fmt_i(fmt), .video_mode_i(mode),
		.frame_rate_i(rate), .iso_speed_i(spd), .scal_wide_i(wide),
		.trig_src_sw_i(src_sw), .trig_style_i(style),
		.frame_done_i(done), .frame_req_o(freq), .sw_trigger_o(trig),
		.setting_fault_o(fault), .irq_o(irq)
	);

	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end

	task automatic report_and_stop;
		if (failures == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [33:0] seen, exp, input string msg);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : chk

	task automatic guard(inout int n);
		n++;
		if (n > 60) begin
			failures++;
			report_and_stop;
		end
	endtask : guard

	task automatic wr(input vccr_addr_t a, input logic [31:0] d,
			input logic [1:0] rs);
		logic pa, pw, ha, hw, hb;
		int n;
		pa = 1'b1;
		pw = 1'b1;
		hb = 1'b0;
		n = 0;
		wq.push_back({32'h0, rs});
		@(posedge ref_clk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!hb) begin
			@(negedge ref_clk_i);
			ha = awready;
			hw = wready;
			hb = bvalid;
			@(posedge ref_clk_i);
			if (pa && ha) begin
				awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (pw && hw) begin
				wvalid <= 1'b0;
				pw = 1'b0;
			end
			if (hb)
				bready <= 1'b0;
			guard(n);
		end
	endtask : wr

	task automatic rd(input vccr_addr_t a, input logic [31:0] d,
			input logic [1:0] rs);
		logic pa, ha, hr;
		int n;
		pa = 1'b1;
		hr = 1'b0;
		n = 0;
		rq.push_back({d, rs});
		@(posedge ref_clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!hr) begin
			@(negedge ref_clk_i);
			ha = arready;
			hr = rvalid;
			@(posedge ref_clk_i);
			if (pa && ha) begin
				arvalid <= 1'b0;
				pa = 1'b0;
			end
			if (hr)
				rready <= 1'b0;
			guard(n);
		end
	endtask : rd

	task automatic set(input logic [2:0] sf, sm, sr, input logic [1:0] ss,
			input logic sw);
		@(posedge ref_clk_i);
		fmt <= sf;
		mode <= sm;
		rate <= sr;
		spd <= ss;
		wide <= sw;
		repeat (2) @(posedge ref_clk_i);
	endtask : set

	function automatic logic [31:0] dep(input logic [2:0] df, dm,
			input logic dw);
		logic w16;
		w16 = (df == FMT_SCAL) ? dw : ((df == 3'h0) ? dm == 3'h6 : dm == 3'h5);
		return {24'h0, w16 ? DEPTH_MONO16 : DEPTH_MONO8};
	endfunction : dep

	// the watcher takes the oldest note whenever a response is handed over
	always @(posedge ref_clk_i) begin
		if (bvalid === 1'b1 && bready === 1'b1)
			chk({32'h0, bresp}, wq.pop_front(), "write response");
		if (rvalid === 1'b1 && rready === 1'b1)
			chk({rdata, rresp}, rq.pop_front(), "read data");
		if (trig === 1'b1)
			trig_cycles++;
	end

	logic [12:0] tbl [7] = '{13'h0024, 13'h0c25, 13'h0305, 13'h0523,
		13'h0855, 13'h18a5, 13'h01c6};
	logic [2:0]  fmts [4] = '{3'h0, 3'h1, 3'h2, FMT_SCAL};

	initial begin
		void'($urandom(10809));
		{awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
		{arvalid, rready, done, src_sw, mode, rate, wide, style} = '0;
		wstrb = 4'hf;
		fmt = FMT_SCAL;
		spd = 2'h2;
		arst_n_i = 1'b0;
		repeat (16) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
		rd(OFS_SHOT, 32'h0, RESP_OKAY);
		rd(OFS_TRIG, 32'h0, RESP_OKAY);
		rd(OFS_IRQ_MSK, 32'h0, RESP_OKAY);
		rd(OFS_FAULT, 32'h0, RESP_OKAY);
		rd(OFS_DEPTH, 32'h8, RESP_OKAY);
		set(FMT_SCAL, 3'h0, 3'h0, 2'h2, 1'b1);
		rd(OFS_DEPTH, 32'ha, RESP_OKAY);
		// each entry: format, mode, rate, speed, expected fault
		foreach (tbl[i]) begin
			set(tbl[i][12:10], tbl[i][9:7], tbl[i][6:4], tbl[i][2:1], 1'b0);
			chk(fault, tbl[i][0], "fault flag");
			rd(OFS_FAULT, {31'h0, tbl[i][0]}, RESP_OKAY);
		end
		repeat (6) begin
			f = 3'($urandom % 3);
			m = 3'($urandom % 6);
			r = 3'($urandom % 5);
			set(f, m, r, 2'h2, 1'b0);
			chk(fault, 1'b0, "fault flag");
			rd(OFS_DEPTH, dep(f, m, 1'b0), RESP_OKAY);
		end
		foreach (fmts[i]) begin
			set(fmts[i], 3'h0, 3'h0, 2'h2, 1'b0);
			wr(OFS_SHOT, 32'hffff0002, RESP_OKAY);
			chk(freq, 1'b0, "burst bits started a frame");
			wr(OFS_SHOT, 32'hffff0003, RESP_OKAY);
			chk(freq, 1'b1, "frame request");
			rd(OFS_SHOT, 32'h1, RESP_OKAY);
			@(posedge ref_clk_i);
			done <= 1'b1;
			@(posedge ref_clk_i);
			done <= 1'b0;
			@(posedge ref_clk_i);
			chk(freq, 1'b0, "frame request not cleared");
			rd(OFS_SHOT, 32'h0, RESP_OKAY);
		end
		set(3'h4, 3'h0, 3'h0, 2'h2, 1'b0);
		wr(OFS_SHOT, 32'h1, RESP_OKAY);
		chk(freq, 1'b0, "frame request in bad format");
		@(posedge ref_clk_i);
		src_sw <= 1'b1;
		n0 = trig_cycles;
		wr(OFS_TRIG, 32'h1, RESP_OKAY);
		repeat (2) @(posedge ref_clk_i);
		chk(32'(trig_cycles - n0), 34'h1, "trigger pulse length");
		rd(OFS_TRIG, 32'h0, RESP_OKAY);
		style <= 4'h1;
		wr(OFS_TRIG, 32'hffffffff, RESP_OKAY);
		chk(trig, 1'b1, "trigger held");
		rd(OFS_TRIG, 32'h1, RESP_OKAY);
		src_sw <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		chk(trig, 1'b0, "trigger with other origin");
		wr(OFS_TRIG, 32'h0, RESP_OKAY);
		src_sw <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		chk(trig, 1'b0, "trigger release");
		rd(OFS_IRQ_STS, 32'h7, RESP_OKAY);
		chk(irq, 1'b0, "masked interrupt");
		wr(OFS_IRQ_MSK, 32'hffffffff, RESP_OKAY);
		rd(OFS_IRQ_MSK, 32'h7, RESP_OKAY);
		chk(irq, 1'b1, "interrupt");
		wr(OFS_IRQ_STS, 32'h2, RESP_OKAY);
		rd(OFS_IRQ_STS, 32'h5, RESP_OKAY);
		wr(OFS_IRQ_STS, 32'h5, RESP_OKAY);
		chk(irq, 1'b0, "cleared interrupt");
		wr(12'h700, 32'h1, RESP_SLVERR);
		rd(12'h700, 32'h0, RESP_SLVERR);
		repeat (2) @(posedge ref_clk_i);
		report_and_stop;
	end
endmodule : testbench
